/* rtl/dmt_pkg.sv */
// Purpose: shared constants and types of the demand maximum tracker
// Assumes: one 200 MHz core clock, 16-bit register words
// Notes: register offsets are the word addresses seen on the register port
package dmt_pkg;
	localparam int SAMPLE_W = 16;
	localparam int MEAN_W = 18;
	localparam int ACC_W = 48;
	localparam int CNT_W = 32;
	localparam int STAMP_W = 32;
	localparam int NQ = 15;
	localparam int NRANK = 3;
	localparam int NPHASE = 3;

	localparam logic [15:0] PERIOD_LEN_ADDR = 16'h00CE;
	localparam logic [15:0] CAPTURE_ADDR = 16'h00CF;
	localparam logic [15:0] SYNC_SEL_ADDR = 16'h00D0;
	localparam logic [15:0] CLEAR_ADDR = 16'h01FA;

	localparam logic [15:0] PERIOD_LEN_RST = 16'h0384;
	localparam logic [15:0] CAPTURE_RST = 16'h000A;
	localparam logic [15:0] SYNC_SEL_RST = 16'h0000;

	localparam logic [15:0] PERIOD_MIN = 16'h012C;
	localparam logic [15:0] PERIOD_MAX = 16'h0E10;
	localparam logic [15:0] CAPTURE_MIN = 16'h0001;
	localparam logic [15:0] CAPTURE_MAX = 16'h0014;
	localparam logic [15:0] SYNC_INTERNAL = 16'h0000;
	localparam logic [15:0] SYNC_EXT_NO = 16'h0001;
	localparam logic [15:0] SYNC_EXT_NC = 16'h0002;
	localparam logic [15:0] CLEAR_CMD = 16'h0001;
	localparam logic [15:0] SECS_PER_HOUR = 16'h0E10;

	localparam int CLK_HZ = 200_000_000;
	localparam int TICK_S = 1;
	localparam int TICK_CYCLES = CLK_HZ * TICK_S;
	localparam int TICK_W = 28;

	typedef struct packed {
		logic [NPHASE-1:0][SAMPLE_W-1:0] current;
		logic [NPHASE-1:0][SAMPLE_W-1:0] power;
		logic [NPHASE-1:0][SAMPLE_W-1:0] apparent;
	} dmt_meas_t;

	typedef struct packed {
		logic [MEAN_W-1:0] value;
		logic [STAMP_W-1:0] stamp;
	} dmt_peak_t;

	typedef enum {ST_IDLE, ST_LOAD, ST_DIV, ST_INSERT} dmt_state_t;
endpackage : dmt_pkg

/* rtl/dmt_demand_maximum_tracker.sv */
// Purpose: period-mean demand tracking with top-three maxima per quantity
// Assumes: samples arrive on core_clk from the measurement engine; syncPin is asynchronous
// Notes: one shared serial divider forms the fifteen means after each period close
`timescale 1ns/100ps

// Overview of operation
// - average every quantity over a period of 300 to 3600 s, default 900 s
// - periods start from internal seconds aligned to set point or hour, or input pulse
// - external pulses accepted using a capture time of 1 to 20 s, default 10 s
// - sync selection 0 internal, 1 normally-open contact, 2 normally-closed contact
// - keep three highest period means per quantity, each with its time stamp
// - quantities: phase currents, signed phase and total power, phase and total apparent
// - signed samples split into positive and negative accumulators before averaging
// - signed totals are summed over phases first, then split by sign
// - writing 1 to the clear register wipes all stored maxima
// - a period mean above the smallest stored maximum is inserted in order
module dmt_demand_maximum_tracker #(
	parameter int TICK_CYCLES = dmt_pkg::TICK_CYCLES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	output logic [15:0] regRdData,
	input wire logic sampleValid,
	input wire dmt_pkg::dmt_meas_t sample,
	input wire logic timeSet,
	input wire logic [dmt_pkg::STAMP_W-1:0] timeValue,
	input wire logic syncPin,
	input wire logic [3:0] peakQty,
	input wire logic [1:0] peakRank,
	output dmt_pkg::dmt_peak_t peakData,
	output logic periodClosed
);
	localparam logic [dmt_pkg::TICK_W-1:0] TICK_LAST = dmt_pkg::TICK_W'(TICK_CYCLES - 1);

	logic [15:0] periodLen, captureTime, syncSel;
	logic [15:0] next_periodLen, next_captureTime, next_syncSel, next_regRdData;
	logic clearPulse;

	always_comb
	begin
		next_periodLen = periodLen;
		next_captureTime = captureTime;
		next_syncSel = syncSel;
		next_regRdData = regRdData;
		clearPulse = 1'b0;
		// out-of-range values are ignored so the block never runs on an illegal setting
		if (regWrite)
		begin
			case (regAddr)
				dmt_pkg::PERIOD_LEN_ADDR:
					if (regWrData >= dmt_pkg::PERIOD_MIN && regWrData <= dmt_pkg::PERIOD_MAX)
						next_periodLen = regWrData;
				dmt_pkg::CAPTURE_ADDR:
					if (regWrData >= dmt_pkg::CAPTURE_MIN && regWrData <= dmt_pkg::CAPTURE_MAX)
						next_captureTime = regWrData;
				dmt_pkg::SYNC_SEL_ADDR:
					if (regWrData <= dmt_pkg::SYNC_EXT_NC)
						next_syncSel = regWrData;
				dmt_pkg::CLEAR_ADDR:
					clearPulse = (regWrData == dmt_pkg::CLEAR_CMD);
				default: ;
			endcase
		end
		if (regRead)
		begin
			case (regAddr)
				dmt_pkg::PERIOD_LEN_ADDR: next_regRdData = periodLen;
				dmt_pkg::CAPTURE_ADDR: next_regRdData = captureTime;
				dmt_pkg::SYNC_SEL_ADDR: next_regRdData = syncSel;
				default: next_regRdData = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			periodLen <= dmt_pkg::PERIOD_LEN_RST;
			captureTime <= dmt_pkg::CAPTURE_RST;
			syncSel <= dmt_pkg::SYNC_SEL_RST;
			regRdData <= 16'h0000;
		end
		else
		begin
			periodLen <= next_periodLen;
			captureTime <= next_captureTime;
			syncSel <= next_syncSel;
			regRdData <= next_regRdData;
		end
	end

	// one-second time base, time stamp and period boundaries
	logic [dmt_pkg::TICK_W-1:0] tickCnt, next_tickCnt;
	logic [dmt_pkg::STAMP_W-1:0] timeNow, next_timeNow;
	logic [15:0] hourSec, periodSec, next_hourSec, next_periodSec;
	logic tick, hourEnd, internalEnd, extEnd, periodEnd;

	always_comb
	begin
		tick = (tickCnt == TICK_LAST);
		hourEnd = tick && (hourSec == dmt_pkg::SECS_PER_HOUR - 16'h0001);
		internalEnd = (syncSel == dmt_pkg::SYNC_INTERNAL) && (timeSet || hourEnd ||
			(tick && (periodSec >= periodLen - 16'h0001)));
		periodEnd = internalEnd || extEnd;
		next_tickCnt = tick ? '0 : tickCnt + 1'b1;
		next_timeNow = timeSet ? timeValue : (tick ? timeNow + 1'b1 : timeNow);
		next_hourSec = (timeSet || hourEnd) ? 16'h0000 : (tick ? hourSec + 16'h0001 : hourSec);
		next_periodSec = periodEnd ? 16'h0000 : (tick ? periodSec + 16'h0001 : periodSec);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			tickCnt <= '0;
			timeNow <= '0;
			hourSec <= 16'h0000;
			periodSec <= 16'h0000;
		end
		else
		begin
			tickCnt <= next_tickCnt;
			timeNow <= next_timeNow;
			hourSec <= next_hourSec;
			periodSec <= next_periodSec;
		end
	end

	// external contact: synchronised, polarity chosen, then held off for the capture time
	logic syncMeta, syncStable, activePrev;
	logic [15:0] lockout, next_lockout;
	logic active;

	always_comb
	begin
		active = (syncSel == dmt_pkg::SYNC_EXT_NC) ? !syncStable : syncStable;
		extEnd = (syncSel != dmt_pkg::SYNC_INTERNAL) && active && !activePrev &&
			(lockout == 16'h0000);
		next_lockout = extEnd ? captureTime :
			((tick && lockout != 16'h0000) ? lockout - 16'h0001 : lockout);
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			syncMeta <= 1'b0;
			syncStable <= 1'b0;
			activePrev <= 1'b1;
			lockout <= 16'h0000;
		end
		else
		begin
			syncMeta <= syncPin;
			syncStable <= syncMeta;
			activePrev <= active;
			lockout <= next_lockout;
		end
	end

	// quantity formation
	logic [dmt_pkg::MEAN_W-1:0] qVal [dmt_pkg::NQ];
	logic signed [dmt_pkg::MEAN_W-1:0] pw, pTot;
	logic [dmt_pkg::MEAN_W-1:0] sTot;

	always_comb
	begin
		pTot = '0;
		sTot = '0;
		pw = '0;
		for (int i = 0; i < dmt_pkg::NPHASE; i++)
		begin
			pw = dmt_pkg::MEAN_W'($signed(sample.power[i]));
			qVal[i] = dmt_pkg::MEAN_W'(sample.current[i]);
			qVal[3 + i] = (pw > 0) ? pw : '0;
			qVal[6 + i] = (pw < 0) ? -pw : '0;
			qVal[11 + i] = dmt_pkg::MEAN_W'(sample.apparent[i]);
			pTot = pTot + pw;
			sTot = sTot + dmt_pkg::MEAN_W'(sample.apparent[i]);
		end
		qVal[9] = (pTot > 0) ? pTot : '0;
		qVal[10] = (pTot < 0) ? -pTot : '0;
		qVal[14] = sTot;
	end

	// accumulators; a sample in the closing cycle already belongs to the new period
	dmt_pkg::dmt_state_t state, next_state;
	logic pending, next_pending, closeNow;
	logic [dmt_pkg::ACC_W-1:0] closedArr [dmt_pkg::NQ];
	logic [dmt_pkg::CNT_W-1:0] cnt, closedCnt, next_cnt, next_closedCnt;

	assign closeNow = (periodEnd || pending) && (state == dmt_pkg::ST_IDLE);

	for (genvar g = 0; g < dmt_pkg::NQ; g++)
	begin : gen_acc
		logic [dmt_pkg::ACC_W-1:0] acc, closed, next_acc, next_closed, inc;
		always_comb
		begin
			inc = sampleValid ? dmt_pkg::ACC_W'(qVal[g]) : '0;
			next_closed = closeNow ? acc : closed;
			next_acc = closeNow ? inc : acc + inc;
		end
		always_ff @(posedge core_clk or negedge resetn)
		begin
			if (!resetn)
			begin
				acc <= '0;
				closed <= '0;
			end
			else
			begin
				acc <= next_acc;
				closed <= next_closed;
			end
		end
		assign closedArr[g] = closed;
	end

	// serial restoring divider and ordered insertion, one quantity at a time
	logic [3:0] qIdx, next_qIdx;
	logic [5:0] bitIdx, next_bitIdx;
	logic [dmt_pkg::ACC_W-1:0] dvd, next_dvd;
	logic [dmt_pkg::CNT_W:0] rem, next_rem, remShift;
	logic [dmt_pkg::STAMP_W-1:0] closeStamp, next_closeStamp;
	logic [dmt_pkg::MEAN_W-1:0] mean;
	dmt_pkg::dmt_peak_t peaks [dmt_pkg::NQ][dmt_pkg::NRANK];
	dmt_pkg::dmt_peak_t next_peaks [dmt_pkg::NQ][dmt_pkg::NRANK];
	dmt_pkg::dmt_peak_t newPeak, next_peakData;

	always_comb
	begin
		next_state = state;
		next_qIdx = qIdx;
		next_bitIdx = bitIdx;
		next_dvd = dvd;
		next_rem = rem;
		next_pending = (periodEnd || pending) && !closeNow;
		// the stamp includes the second whose tick closes the period, so it marks the period end
		next_closeStamp = closeNow ? (tick ? timeNow + 1'b1 : timeNow) : closeStamp;
		next_cnt = closeNow ? dmt_pkg::CNT_W'(sampleValid) : cnt + dmt_pkg::CNT_W'(sampleValid);
		next_closedCnt = closeNow ? cnt : closedCnt;
		next_peaks = peaks;
		remShift = {rem[dmt_pkg::CNT_W-1:0], dvd[dmt_pkg::ACC_W-1]};
		// saturate rather than wrap if a mean ever exceeds the stored width
		mean = (closedCnt == '0) ? '0 :
			((|dvd[dmt_pkg::ACC_W-1:dmt_pkg::MEAN_W]) ? '1 : dvd[dmt_pkg::MEAN_W-1:0]);
		newPeak = '{value: mean, stamp: closeStamp};
		case (state)
			dmt_pkg::ST_IDLE:
				if (closeNow)
				begin
					next_qIdx = 4'h0;
					next_state = dmt_pkg::ST_LOAD;
				end
			dmt_pkg::ST_LOAD:
			begin
				next_dvd = closedArr[qIdx];
				next_rem = '0;
				next_bitIdx = 6'h00;
				next_state = dmt_pkg::ST_DIV;
			end
			dmt_pkg::ST_DIV:
			begin
				if (remShift >= {1'b0, closedCnt})
				begin
					next_rem = remShift - {1'b0, closedCnt};
					next_dvd = {dvd[dmt_pkg::ACC_W-2:0], 1'b1};
				end
				else
				begin
					next_rem = remShift;
					next_dvd = {dvd[dmt_pkg::ACC_W-2:0], 1'b0};
				end
				next_bitIdx = bitIdx + 6'h01;
				if (bitIdx == 6'(dmt_pkg::ACC_W - 1))
					next_state = dmt_pkg::ST_INSERT;
			end
			dmt_pkg::ST_INSERT:
			begin
				if (mean > peaks[qIdx][0].value)
				begin
					next_peaks[qIdx][2] = peaks[qIdx][1];
					next_peaks[qIdx][1] = peaks[qIdx][0];
					next_peaks[qIdx][0] = newPeak;
				end
				else if (mean > peaks[qIdx][1].value)
				begin
					next_peaks[qIdx][2] = peaks[qIdx][1];
					next_peaks[qIdx][1] = newPeak;
				end
				else if (mean > peaks[qIdx][2].value)
					next_peaks[qIdx][2] = newPeak;
				next_qIdx = qIdx + 4'h1;
				next_state = (qIdx == 4'(dmt_pkg::NQ - 1)) ? dmt_pkg::ST_IDLE : dmt_pkg::ST_LOAD;
			end
			default: next_state = dmt_pkg::ST_IDLE;
		endcase
		if (clearPulse)
		begin
			for (int q = 0; q < dmt_pkg::NQ; q++)
				for (int r = 0; r < dmt_pkg::NRANK; r++)
					next_peaks[q][r] = '0;
		end
		next_peakData = (peakQty < 4'(dmt_pkg::NQ) && peakRank < 2'(dmt_pkg::NRANK)) ?
			peaks[peakQty][peakRank] : '0;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= dmt_pkg::ST_IDLE;
			qIdx <= 4'h0;
			bitIdx <= 6'h00;
			dvd <= '0;
			rem <= '0;
			pending <= 1'b0;
			closeStamp <= '0;
			cnt <= '0;
			closedCnt <= '0;
			peaks <= '{default: '0};
			peakData <= '0;
			periodClosed <= 1'b0;
		end
		else
		begin
			state <= next_state;
			qIdx <= next_qIdx;
			bitIdx <= next_bitIdx;
			dvd <= next_dvd;
			rem <= next_rem;
			pending <= next_pending;
			closeStamp <= next_closeStamp;
			cnt <= next_cnt;
			closedCnt <= next_closedCnt;
			peaks <= next_peaks;
			peakData <= next_peakData;
			periodClosed <= closeNow;
		end
	end
endmodule : dmt_demand_maximum_tracker

/* tb/dmt_tracker_assertions.sv */
// Purpose: port checks for the demand maximum tracker
// Assumes: one clock domain, resetn active low
// Notes: sync mode is mirrored from register writes
`timescale 1ns/100ps
module dmt_tracker_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWrData,
	input wire logic [15:0] regRdData,
	input wire logic syncPin,
	input wire logic [3:0] peakQty,
	input wire dmt_pkg::dmt_peak_t peakData,
	input wire logic periodClosed
);
	logic extMode;
	logic next_extMode;
	logic pinLast;
	logic [3:0] pinAge;
	logic [3:0] next_pinAge;
	always_comb
	begin
		next_extMode = extMode;
		if (regWrite && regAddr == dmt_pkg::SYNC_SEL_ADDR && regWrData <= dmt_pkg::SYNC_EXT_NC)
			next_extMode = (regWrData != dmt_pkg::SYNC_INTERNAL);
		next_pinAge = (syncPin != pinLast) ? 4'h0 : pinAge + {3'h0, pinAge != 4'hF};
	end
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			extMode <= 1'b0;
			pinLast <= 1'b0;
			pinAge <= 4'hF;
		end
		else
		begin
			extMode <= next_extMode;
			pinLast <= syncPin;
			pinAge <= next_pinAge;
		end
	end
	default clocking dmtCk @(posedge core_clk);
	endclocking
	default disable iff (!resetn);
	sequence s_read(logic [15:0] addr);
		regRead && regAddr == addr;
	endsequence
	sequence s_clearCmd;
		regWrite && regAddr == dmt_pkg::CLEAR_ADDR && regWrData == dmt_pkg::CLEAR_CMD;
	endsequence
	chk_clear_wipes: assert property (s_clearCmd |-> ##2 peakData == '0)
		else $error("peaks not cleared");
	chk_clear_reads: assert property (s_read(dmt_pkg::CLEAR_ADDR) |=> regRdData == 16'h0000)
		else $error("clear register read not zero");
	chk_period_range: assert property (s_read(dmt_pkg::PERIOD_LEN_ADDR) |=>
		regRdData inside {[dmt_pkg::PERIOD_MIN:dmt_pkg::PERIOD_MAX]})
		else $error("period length out of range");
	chk_capture_range: assert property (s_read(dmt_pkg::CAPTURE_ADDR) |=>
		regRdData inside {[dmt_pkg::CAPTURE_MIN:dmt_pkg::CAPTURE_MAX]})
		else $error("capture time out of range");
	chk_select_range: assert property (s_read(dmt_pkg::SYNC_SEL_ADDR) |=>
		regRdData <= dmt_pkg::SYNC_EXT_NC)
		else $error("sync select out of range");
	chk_close_single: assert property (periodClosed |=> !periodClosed [*8])
		else $error("period close repeated");
	// a late close in external mode would mean ticks still close periods
	chk_ext_pin: assert property (periodClosed && extMode |-> pinAge <= 4'h8)
		else $error("external close without pin edge");
	chk_qty_range: assert property (peakQty > 4'hE |=> peakData == '0)
		else $error("peak shown for missing quantity");
endmodule : dmt_tracker_assertions

bind dmt_demand_maximum_tracker dmt_tracker_assertions i_chk (
	.core_clk(core_clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
	.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .syncPin(syncPin),
	.peakQty(peakQty), .peakData(peakData), .periodClosed(periodClosed)
);

/* tb/dmt_meter_model.sv */
// Purpose: measurement engine and sync contact in front of the tracker
// Assumes: driven at the falling edge of core_clk
// Notes: idle sample lines carry inverted data so stale values never look valid
`timescale 1ns/100ps
module dmt_meter_model (
	input wire logic core_clk,
	output logic sampleValid,
	output dmt_pkg::dmt_meas_t sample,
	output logic syncPin
);
	integer seed;
	logic [159:0] raw;
	initial
	begin
		seed = 32'hA846;
		sampleValid = 1'b0;
		sample = '0;
		syncPin = 1'b0;
	end
	task automatic burst(input int n);
		for (int k = 0; k < n; k++)
		begin
			@(negedge core_clk);
			raw = {$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)};
			sampleValid = 1'b1;
			sample = raw[143:0];
			@(negedge core_clk);
			sampleValid = 1'b0;
			sample = ~sample;
		end
	endtask : burst
	// the contact only moves; edge sense and lockout stay with the tracker
	task automatic setPin(input logic level);
		@(negedge core_clk);
		syncPin = level;
	endtask : setPin
endmodule : dmt_meter_model

/* tb/tb_top.sv */
// Purpose: self-checking bench for the demand maximum tracker
// Assumes: one second shortened to 20 clock cycles
// Notes: peaks are predicted by an integer model fed from the sample port
`timescale 1ns/100ps
module tb_top;
	localparam int TICK = 20;
	logic core_clk;
	logic resetn;
	logic regWrite;
	logic regRead;
	logic [15:0] regAddr;
	logic [15:0] regWrData;
	logic [15:0] regRdData;
	logic sampleValid;
	dmt_pkg::dmt_meas_t sample;
	logic timeSet;
	logic [dmt_pkg::STAMP_W-1:0] timeValue;
	logic syncPin;
	logic [3:0] peakQty;
	logic [1:0] peakRank;
	dmt_pkg::dmt_peak_t peakData;
	logic periodClosed;
	int n_mismatch;
	int n_tests;
	int nClose;
	int nBase;
	longint acc [15];
	longint top [15][3];
	longint topS [15][3];
	longint stampNow;
	longint cnt;
	longint pw;
	longint tot;
	longint sTot;
	realtime tPrev;
	realtime tNow;
	logic [15:0] rd;
	logic [15:0] regList [3];
	logic [15:0] rstList [3];
	logic [15:0] badList [3];
	logic [15:0] goodList [3];
	dmt_demand_maximum_tracker #(.TICK_CYCLES(TICK)) i_dut (
		.core_clk(core_clk), .resetn(resetn), .regWrite(regWrite), .regRead(regRead),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
		.sampleValid(sampleValid), .sample(sample), .timeSet(timeSet),
		.timeValue(timeValue), .syncPin(syncPin), .peakQty(peakQty),
		.peakRank(peakRank), .peakData(peakData), .periodClosed(periodClosed)
	);
	dmt_meter_model i_partner (
		.core_clk(core_clk), .sampleValid(sampleValid), .sample(sample), .syncPin(syncPin)
	);
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		if (periodClosed === 1'b1)
			nClose++;
		if (sampleValid === 1'b1)
		begin
			tot = 0;
			sTot = 0;
			for (int i = 0; i < 3; i++)
			begin
				pw = $signed(sample.power[i]);
				acc[i] += sample.current[i];
				acc[3 + i] += (pw > 0) ? pw : 0;
				acc[6 + i] += (pw < 0) ? -pw : 0;
				acc[11 + i] += sample.apparent[i];
				tot += pw;
				sTot += sample.apparent[i];
			end
			acc[9] += (tot > 0) ? tot : 0;
			acc[10] += (tot < 0) ? -tot : 0;
			acc[14] += sTot;
			cnt++;
		end
	end
	task automatic wrap_up();
		$display("comparisons %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : wrap_up
	task automatic cmpWord(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : cmpWord
	task automatic cmpPeak(input logic [17:0] got, input logic [17:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: peak %h expected %h", $time, got, exp);
		end
	endtask : cmpPeak
	task automatic cmpStamp(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: stamp %h expected %h", $time, got, exp);
		end
	endtask : cmpStamp
	task automatic wrReg(input logic [15:0] a, input logic [15:0] d);
		@(negedge core_clk);
		regWrite = 1'b1;
		regAddr = a;
		regWrData = d;
		@(negedge core_clk);
		regWrite = 1'b0;
	endtask : wrReg
	task automatic rdReg(input logic [15:0] a, output logic [15:0] d);
		@(negedge core_clk);
		regRead = 1'b1;
		regAddr = a;
		@(negedge core_clk);
		regRead = 1'b0;
		@(negedge core_clk);
		d = regRdData;
	endtask : rdReg
	task automatic waitClose(input int lim);
		int k;
		for (k = 0; k < lim && periodClosed !== 1'b1; k++)
			@(negedge core_clk);
		if (k == lim)
		begin
			n_mismatch++;
			$display("wrong value at %0t: no period close", $time);
			wrap_up();
		end
		tNow = $realtime;
		cmpWord(16'($rtoi((tNow - tPrev) / (5.0 * TICK) + 0.5)), dmt_pkg::PERIOD_MIN);
		tPrev = tNow;
	endtask : waitClose
	task automatic modelClose();
		longint m;
		longint s;
		// internal periods here all run at the shortest length, so each ends that much later
		stampNow += dmt_pkg::PERIOD_MIN;
		for (int q = 0; q < 15; q++)
		begin
			m = (cnt > 0) ? acc[q] / cnt : 0;
			if (m > top[q][2])
			begin
				top[q][2] = m;
				topS[q][2] = stampNow;
			end
			for (int r = 2; r > 0; r--)
				if (top[q][r] > top[q][r - 1])
				begin
					m = top[q][r];
					s = topS[q][r];
					top[q][r] = top[q][r - 1];
					topS[q][r] = topS[q][r - 1];
					top[q][r - 1] = m;
					topS[q][r - 1] = s;
				end
			acc[q] = 0;
		end
		cnt = 0;
	endtask : modelClose
	task automatic checkAll();
		for (int q = 0; q < 16; q++)
			for (int r = 0; r < 4; r++)
			begin
				@(negedge core_clk);
				peakQty = q[3:0];
				peakRank = r[1:0];
				@(negedge core_clk);
				cmpPeak(peakData.value, (q < 15 && r < 3) ? 18'(top[q][r]) : 18'h00000);
				cmpStamp(peakData.stamp, (q < 15 && r < 3) ? 32'(topS[q][r]) : 32'h00000000);
			end
	endtask : checkAll
	initial
	begin
		resetn = 1'b0;
		regWrite = 1'b0;
		regRead = 1'b0;
		regAddr = 16'h0000;
		regWrData = 16'h0000;
		timeSet = 1'b0;
		timeValue = 32'h000003E8;
		peakQty = 4'h0;
		peakRank = 2'h0;
		n_mismatch = 0;
		n_tests = 0;
		nClose = 0;
		cnt = 0;
		foreach (acc[q]) acc[q] = 0;
		foreach (top[q, r]) top[q][r] = 0;
		foreach (topS[q, r]) topS[q][r] = 0;
		stampNow = 0;
		regList = '{dmt_pkg::PERIOD_LEN_ADDR, dmt_pkg::CAPTURE_ADDR, dmt_pkg::SYNC_SEL_ADDR};
		rstList = '{dmt_pkg::PERIOD_LEN_RST, dmt_pkg::CAPTURE_RST, dmt_pkg::SYNC_SEL_RST};
		badList = '{16'h0E11, 16'h0000, 16'h0003};
		goodList = '{dmt_pkg::PERIOD_MIN, dmt_pkg::CAPTURE_MAX, dmt_pkg::SYNC_INTERNAL};
		repeat (16) @(posedge core_clk);
		@(negedge core_clk);
		resetn = 1'b1;
		for (int i = 0; i < 3; i++)
		begin
			rdReg(regList[i], rd);
			cmpWord(rd, rstList[i]);
			wrReg(regList[i], badList[i]);
			rdReg(regList[i], rd);
			cmpWord(rd, rstList[i]);
			wrReg(regList[i], goodList[i]);
			rdReg(regList[i], rd);
			cmpWord(rd, goodList[i]);
		end
		rdReg(16'h00D1, rd);
		cmpWord(rd, 16'h0000);
		rdReg(dmt_pkg::CLEAR_ADDR, rd);
		cmpWord(rd, 16'h0000);
		@(negedge core_clk);
		timeSet = 1'b1;
		@(negedge core_clk);
		timeSet = 1'b0;
		tPrev = $realtime;
		stampNow = timeValue;
		repeat (800) @(negedge core_clk);
		for (int p = 0; p < 3; p++)
		begin
			i_partner.burst(30 + 20 * p);
			waitClose(6400);
			modelClose();
			repeat (800) @(negedge core_clk);
			checkAll();
		end
		wrReg(dmt_pkg::CLEAR_ADDR, 16'h0002);
		checkAll();
		wrReg(dmt_pkg::CLEAR_ADDR, dmt_pkg::CLEAR_CMD);
		foreach (top[q, r]) top[q][r] = 0;
		foreach (topS[q, r]) topS[q][r] = 0;
		checkAll();
		wrReg(dmt_pkg::CAPTURE_ADDR, 16'h0002);
		wrReg(dmt_pkg::SYNC_SEL_ADDR, dmt_pkg::SYNC_EXT_NO);
		repeat (800) @(negedge core_clk);
		nBase = nClose;
		i_partner.setPin(1'b1);
		repeat (10) @(negedge core_clk);
		cmpWord(16'(nClose - nBase), 16'h0001);
		i_partner.setPin(1'b0);
		repeat (4) @(negedge core_clk);
		i_partner.setPin(1'b1);
		repeat (10) @(negedge core_clk);
		cmpWord(16'(nClose - nBase), 16'h0001);
		wrReg(dmt_pkg::SYNC_SEL_ADDR, dmt_pkg::SYNC_EXT_NC);
		// let the evaluation of the last close finish so the next close is not held pending
		repeat (800) @(negedge core_clk);
		i_partner.setPin(1'b0);
		repeat (10) @(negedge core_clk);
		cmpWord(16'(nClose - nBase), 16'h0002);
		wrap_up();
	end
endmodule : tb_top
